// file: hdl/fsp_status_regs.vh
// Constants of the flash status and protection register logic.
// Assumes inclusion by fsp_status_protect.v and fsp_nv_store.v only.
`ifndef FSP_STATUS_REGS_VH
`define FSP_STATUS_REGS_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define FSP_OP_WREN 8'h06
`define FSP_OP_WRDI 8'h04
`define FSP_OP_VWREN 8'h50
`define FSP_OP_RDSR1 8'h05
`define FSP_OP_RDSR2 8'h35
`define FSP_OP_RDSR3 8'h15
`define FSP_OP_WRSR1 8'h01
`define FSP_OP_WRSR2 8'h31
`define FSP_OP_WRSR3 8'h11
`define FSP_OP_PROG 8'h02
`define FSP_OP_SE 8'h20
`define FSP_OP_BE32 8'h52
`define FSP_OP_BE64 8'hD8
`define FSP_OP_CE1 8'hC7
`define FSP_OP_CE2 8'h60
`define FSP_OP_SUSP 8'h75
`define FSP_OP_RESUME 8'h7A
`define FSP_OP_RSTEN 8'h66
`define FSP_OP_RST 8'h99

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSP_SR1_BUSY 0
`define FSP_SR1_WEL 1
`define FSP_SR1_BP_LO 2
`define FSP_SR1_TB 5
`define FSP_SR1_SEC 6
`define FSP_SR1_SRPL 7
`define FSP_SR2_SRPU 0
`define FSP_SR2_QE 1
`define FSP_SR2_LB_LO 3
`define FSP_SR2_CMP 6
`define FSP_SR2_SUS 7
`define FSP_SR3_PIN_FUNCTION_SELECT 7

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define FSP_SR1_WMASK 8'hFC
`define FSP_SR2_WMASK 8'h7B
`define FSP_SR2_VMASK 8'h43
`define FSP_SR3_NVMASK 8'hF4
`define FSP_SR3_VMASK 8'hF7
`define FSP_NV_DEFAULT 24'h000000
`define FSP_CFG_RESET 8'h00

// ----------------------------------------
// Busy durations in mclk cycles
// ----------------------------------------
`define FSP_WRSR_CYCLES 100
`define FSP_PROG_CYCLES 200
`define FSP_SE_CYCLES 1000
`define FSP_BE_CYCLES 2000
`define FSP_CE_CYCLES 4000

`endif

// file: hdl/fsp_nv_store.v
// Non-volatile copy of the status bits, one word of three status bytes.
// Assumes factory reset happens once; ordinary resets never touch it.
`timescale 1ns/1ps
`include "fsp_status_regs.vh"

module fsp_nv_store #(
  parameter WIDTH = 24
) (
  // Clock and factory reset
  input wire mclk,
  input wire factoryRst_n,
  // Write port
  input wire wrEn,
  input wire [WIDTH-1:0] wrData,
  // Registered read data
  output reg [WIDTH-1:0] rdData
);

  always @(posedge mclk or negedge factoryRst_n) begin
    if (!factoryRst_n) begin
      rdData <= `FSP_NV_DEFAULT;
    end else if (wrEn) begin
      rdData <= wrData;
    end
  end

endmodule

// file: hdl/fsp_status_protect.v
// Status, configuration and protection bits of a serial NOR flash,
// reached over its serial interface in SPI mode 0 (MSB first).
// Assumes the serial clock is far slower than mclk; all pins are async.
`timescale 1ns/1ps
`include "fsp_status_regs.vh"

// Summary of operation
// - Busy set during program, erase, non-volatile status write
// - While busy, only status reads, suspend and resume accepted
// - Busy clears when the operation ends
// - Write enable sets the write enable latch
// - Latch clears at reset, disable, program, erase
// - Block protect bits stored, default unprotected
// - Top/bottom bit selects protection origin
// - Granularity bit selects sector or block units
// - Complement bit inverts selected protection region
// - Protect 00: writable whenever latch set
// - Protect 01: write-protect pin gates writes
// - Protect 10: locked until next power cycle, software reset or reset pin
// - Protect 11: status writes refused forever
// - Lock-down value returns to 00 on reset
// - Status write data never alters volatile status flags
// - Normal enable: status write updates non-volatile copy
// - Volatile enable: volatile copy only, locks untouched
// - Suspend sets flag; resume or reset clears
// - Lock bits are one-time settable, default zero
// - Quad enable turns control pins into data
// - Pin is hold or reset per select
module fsp_status_protect #(
  parameter CW = 24,
  parameter WRSR_CYCLES = `FSP_WRSR_CYCLES,
  parameter PROG_CYCLES = `FSP_PROG_CYCLES,
  parameter SE_CYCLES = `FSP_SE_CYCLES,
  parameter BE_CYCLES = `FSP_BE_CYCLES,
  parameter CE_CYCLES = `FSP_CE_CYCLES
) (
  // Clock and resets
  input wire mclk,
  input wire arst_n,
  input wire factoryRst_n,
  // Serial link
  input wire chipSelN,
  input wire sclk,
  input wire serialIn,
  output reg serialOut,
  output wire serialOutEn,
  // Control pins
  input wire writeProtectN,
  input wire holdResetN,
  // Protection state towards the array
  output reg [2:0] blockProtect,
  output reg topBottomSelect,
  output reg granularitySelect,
  output reg complementProtect,
  output reg [2:0] securityLock,
  // Status and pin function
  output reg busy,
  output reg writeEnableLatch,
  output reg suspendFlag,
  output reg quadEnable,
  output reg holdActive,
  output reg pinResetActive
);

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  reg [1:0] rstPipe;
  wire rstN;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  wire [4:0] pinRaw;
  reg [4:0] syncA;
  reg [4:0] syncB;
  reg sclkPrev;
  reg csPrev;
  assign pinRaw = {holdResetN, writeProtectN, serialIn, sclk, chipSelN};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
          syncA[gi] <= 1'b1;
          syncB[gi] <= 1'b1;
        end else begin
          syncA[gi] <= pinRaw[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  wire csLow = ~syncB[0];
  wire sclkS = syncB[1];
  wire siS = syncB[2];
  wire wpS = syncB[3];
  wire hrS = syncB[4];

  // ----------------------------------------
  // Volatile status and configuration
  // ----------------------------------------
  reg [5:0] sr1Cfg;
  reg cmpV;
  reg srpU;
  reg [7:0] sr3Cfg;
  reg volWel;
  reg rstArmed;
  reg loadPend;
  reg [CW-1:0] busyCnt;
  wire [23:0] nvRd;
  wire [2:0] lockNv = nvRd[8+`FSP_SR2_LB_LO +: 3];

  wire [7:0] statusOne = {sr1Cfg, writeEnableLatch, busy};
  wire [7:0] statusTwo = {suspendFlag, cmpV, lockNv, 1'b0, quadEnable, srpU};
  wire [7:0] statusThree = sr3Cfg & `FSP_SR3_VMASK;

  // Pin functions; quad mode hands both pins to data
  wire pinHoldMode = ~quadEnable & ~sr3Cfg[`FSP_SR3_PIN_FUNCTION_SELECT];
  wire pinRstMode = ~quadEnable & sr3Cfg[`FSP_SR3_PIN_FUNCTION_SELECT];
  wire holdNow = pinHoldMode & ~hrS & csLow;
  wire hwReset = pinRstMode & ~hrS;
  wire wpHigh = quadEnable | wpS;

  // ----------------------------------------
  // Serial shifter
  // ----------------------------------------
  reg [2:0] bitCnt;
  reg [1:0] byteCnt;
  reg [7:0] shiftIn;
  reg [7:0] opcode;
  reg [7:0] dataOne;
  reg [7:0] dataTwo;
  reg [7:0] outShift;
  reg readAct;
  wire sclkRise = sclkS & ~sclkPrev & csLow & ~holdNow;
  wire sclkFall = ~sclkS & sclkPrev & csLow & ~holdNow;
  wire csRise = ~csLow & csPrev;
  wire [7:0] newByte = {shiftIn[6:0], siS};
  wire byteDone = sclkRise & (bitCnt == 3'h7);
  wire [7:0] rdOp = (byteCnt == 2'h0) ? newByte : opcode;
  wire isRdOp = (rdOp == `FSP_OP_RDSR1) | (rdOp == `FSP_OP_RDSR2) |
    (rdOp == `FSP_OP_RDSR3);
  reg [7:0] rdSel;
  always @* begin
    case (rdOp)
      `FSP_OP_RDSR1: rdSel = statusOne;
      `FSP_OP_RDSR2: rdSel = statusTwo;
      `FSP_OP_RDSR3: rdSel = statusThree;
      default: rdSel = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      sclkPrev <= 1'b0;
      csPrev <= 1'b0;
      bitCnt <= 3'h0;
      byteCnt <= 2'h0;
      shiftIn <= 8'h00;
      opcode <= 8'h00;
      dataOne <= 8'h00;
      dataTwo <= 8'h00;
      outShift <= 8'h00;
      readAct <= 1'b0;
      serialOut <= 1'b0;
    end else begin
      sclkPrev <= sclkS;
      csPrev <= csLow;
      if (!csLow) begin
        bitCnt <= 3'h0;
        byteCnt <= 2'h0;
        readAct <= 1'b0;
      end else if (sclkRise) begin
        shiftIn <= newByte;
        bitCnt <= bitCnt + 3'h1;
        if (byteDone) begin
          if (byteCnt == 2'h0) begin
            opcode <= newByte;
          end else if (byteCnt == 2'h1) begin
            dataOne <= newByte;
          end else if (byteCnt == 2'h2) begin
            dataTwo <= newByte;
          end
          if (byteCnt != 2'h3) begin
            byteCnt <= byteCnt + 2'h1;
          end
          // Reads repeat the live register every byte
          if (isRdOp) begin
            outShift <= rdSel;
            readAct <= 1'b1;
          end
        end
      end else if (sclkFall) begin
        serialOut <= outShift[7];
        outShift <= {outShift[6:0], 1'b0};
      end
    end
  end
  assign serialOutEn = readAct & csLow & ~holdNow;

  // ----------------------------------------
  // Command decode at chip select release
  // ----------------------------------------
  // Commands ending off a byte boundary are dropped
  wire cmdEnd = csRise & (bitCnt == 3'h0) & (byteCnt != 2'h0);
  wire [1:0] nBytes = byteCnt;
  wire isProg = (opcode == `FSP_OP_PROG) & (nBytes == 2'h3);
  wire isSe = (opcode == `FSP_OP_SE) & (nBytes == 2'h3);
  wire isBe = ((opcode == `FSP_OP_BE32) | (opcode == `FSP_OP_BE64)) & (nBytes == 2'h3);
  wire isCe = ((opcode == `FSP_OP_CE1) | (opcode == `FSP_OP_CE2)) & (nBytes == 2'h1);
  wire isWrsr = ((opcode == `FSP_OP_WRSR1) & (nBytes >= 2'h2)) |
    (((opcode == `FSP_OP_WRSR2) | (opcode == `FSP_OP_WRSR3)) & (nBytes == 2'h2));
  wire oneByte = nBytes == 2'h1;
  wire susOk = busy & ~suspendFlag & (opcode == `FSP_OP_SUSP) & oneByte;
  wire resOk = suspendFlag & (opcode == `FSP_OP_RESUME) & oneByte;
  // Busy ignores everything but status reads; suspend and resume
  // are the exceptions that hold and restart a running operation
  wire cmdOk = cmdEnd & (~busy | susOk | resOk);
  wire anyWel = writeEnableLatch | volWel;
  wire arrayOp = isProg | isSe | isBe | isCe;
  wire [1:0] srpMode = {srpU, sr1Cfg[5]};
  reg srWritable;
  always @* begin
    case (srpMode)
      2'b00: srWritable = 1'b1;
      2'b01: srWritable = wpHigh;
      2'b10: srWritable = 1'b0;
      default: srWritable = 1'b0;
    endcase
  end
  wire wrsrGo = cmdOk & isWrsr & anyWel & srWritable;
  wire nvWrite = wrsrGo & writeEnableLatch & ~volWel;
  wire volWrite = wrsrGo & volWel;

  // Proposed bytes from the incoming data
  wire twoData = (opcode == `FSP_OP_WRSR1) & (nBytes == 2'h3);
  wire [7:0] candOne = (opcode == `FSP_OP_WRSR1) ? dataOne : statusOne;
  wire [7:0] candTwo = (opcode == `FSP_OP_WRSR2) ? dataOne :
    (twoData ? dataTwo : statusTwo);
  wire [7:0] candThree = (opcode == `FSP_OP_WRSR3) ? dataOne : statusThree;
  // Lock bits can only ever be set
  wire [2:0] lockNext = lockNv | candTwo[`FSP_SR2_LB_LO +: 3];
  wire [7:0] nvTwo = ({candTwo[7:6], lockNext, candTwo[2:0]} & `FSP_SR2_WMASK);
  wire [23:0] nvWrData = {candThree & `FSP_SR3_NVMASK, nvTwo,
    candOne & `FSP_SR1_WMASK};
  wire nvWrEn = nvWrite;

  fsp_nv_store #(
    .WIDTH(24)
  ) u_nv (
    .mclk(mclk),
    .factoryRst_n(factoryRst_n),
    .wrEn(nvWrEn),
    .wrData(nvWrData),
    .rdData(nvRd)
  );

  // ----------------------------------------
  // Status state machine
  // ----------------------------------------
  wire softRst = cmdOk & rstArmed & (opcode == `FSP_OP_RST) & oneByte;
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      busy <= 1'b0;
      writeEnableLatch <= 1'b0;
      volWel <= 1'b0;
      suspendFlag <= 1'b0;
      busyCnt <= {CW{1'b0}};
      rstArmed <= 1'b0;
      loadPend <= 1'b1;
      sr1Cfg <= 6'h00;
      cmpV <= 1'b0;
      srpU <= 1'b0;
      quadEnable <= 1'b0;
      sr3Cfg <= `FSP_CFG_RESET;
    end else if (loadPend) begin
      loadPend <= 1'b0;
      sr1Cfg <= nvRd[7:2];
      cmpV <= nvRd[8+`FSP_SR2_CMP];
      quadEnable <= nvRd[8+`FSP_SR2_QE];
      sr3Cfg <= nvRd[23:16] & `FSP_SR3_NVMASK;
      // Lock-down never survives a reset
      if (nvRd[8+`FSP_SR2_SRPU] & ~nvRd[`FSP_SR1_SRPL]) begin
        srpU <= 1'b0;
        sr1Cfg[5] <= 1'b0;
      end else begin
        srpU <= nvRd[8+`FSP_SR2_SRPU];
      end
    end else if (softRst | hwReset) begin
      busy <= 1'b0;
      writeEnableLatch <= 1'b0;
      volWel <= 1'b0;
      suspendFlag <= 1'b0;
      busyCnt <= {CW{1'b0}};
      rstArmed <= 1'b0;
      loadPend <= 1'b1;
    end else begin
      if (busy && !suspendFlag) begin
        if (busyCnt <= {{(CW-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          busyCnt <= {CW{1'b0}};
        end else begin
          busyCnt <= busyCnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      if (cmdOk) begin
        rstArmed <= (opcode == `FSP_OP_RSTEN) & oneByte;
        if (opcode != `FSP_OP_VWREN) begin
          volWel <= 1'b0;
        end
        if ((opcode == `FSP_OP_WREN) & oneByte) begin
          writeEnableLatch <= 1'b1;
        end else if ((opcode == `FSP_OP_VWREN) & oneByte) begin
          volWel <= 1'b1;
        end else if ((opcode == `FSP_OP_WRDI) & oneByte) begin
          writeEnableLatch <= 1'b0;
        end else if (susOk) begin
          suspendFlag <= 1'b1;
        end else if (resOk) begin
          suspendFlag <= 1'b0;
        end else if (arrayOp & writeEnableLatch) begin
          writeEnableLatch <= 1'b0;
          busy <= 1'b1;
          if (isProg) begin
            busyCnt <= PROG_CYCLES[CW-1:0];
          end else if (isSe) begin
            busyCnt <= SE_CYCLES[CW-1:0];
          end else if (isBe) begin
            busyCnt <= BE_CYCLES[CW-1:0];
          end else begin
            busyCnt <= CE_CYCLES[CW-1:0];
          end
        end else if (isWrsr) begin
          writeEnableLatch <= 1'b0;
          if (nvWrite) begin
            busy <= 1'b1;
            busyCnt <= WRSR_CYCLES[CW-1:0];
          end
        end
      end
      // Only configurable bits move; busy, latch and suspend do not
      if (nvWrite | volWrite) begin
        sr1Cfg <= candOne[7:2];
        cmpV <= candTwo[`FSP_SR2_CMP];
        quadEnable <= candTwo[`FSP_SR2_QE];
        srpU <= candTwo[`FSP_SR2_SRPU];
        if (volWrite) begin
          sr3Cfg <= candThree & `FSP_SR3_VMASK;
        end else begin
          sr3Cfg <= (candThree & `FSP_SR3_NVMASK) | (sr3Cfg & 8'h03);
        end
      end
    end
  end

  // ----------------------------------------
  // Registered outputs towards the array and pins
  // ----------------------------------------
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      blockProtect <= 3'h0;
      topBottomSelect <= 1'b0;
      granularitySelect <= 1'b0;
      complementProtect <= 1'b0;
      securityLock <= 3'h0;
      holdActive <= 1'b0;
      pinResetActive <= 1'b0;
    end else begin
      blockProtect <= sr1Cfg[2:0];
      topBottomSelect <= sr1Cfg[3];
      granularitySelect <= sr1Cfg[4];
      complementProtect <= cmpV;
      securityLock <= lockNv;
      holdActive <= holdNow;
      pinResetActive <= hwReset;
    end
  end

endmodule

// file: sim/fsp_host_model.sv
// Serial host model: SPI mode 0 frames, MSB first, one command per frame.
// Assumes mclk at 10 MHz; sclk runs at 800 ns only inside frames.
`timescale 1ns/1ps
module fsp_host_model (
  // Clock
  input wire mclk,
  // Serial link
  output logic chipSelN,
  output logic sclk,
  output logic serialIn,
  input wire serialOut
);
  initial begin
    chipSelN = 1'b1;
    sclk = 1'b0;
    serialIn = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge mclk);
    #5;
  endtask

  // Sends nb bytes from the top of tx; rx keeps the last byte read back
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [7:0] rx);
    half();
    chipSelN = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      serialIn = tx[31-i];
      half();
      sclk = 1'b1;
      rx = {rx[6:0], serialOut};
      half();
      sclk = 1'b0;
    end
    half();
    chipSelN = 1'b1;
    // Released line must not keep its last level
    serialIn = ~serialIn;
    repeat (3) half();
  endtask
endmodule

// file: sim/fsp_status_protect_properties.sv
// Checker on the top-level ports of the status and protection logic.
// Assumes commands execute only after chip select has risen.
`timescale 1ns/1ps
module fsp_status_protect_properties (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Observed ports
  input wire chipSelN,
  input wire serialOutEn,
  input wire [2:0] blockProtect,
  input wire busy,
  input wire writeEnableLatch,
  input wire suspendFlag,
  input wire quadEnable,
  input wire holdActive,
  input wire pinResetActive
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_busy_clears_latch: assert property ($rose(busy) |-> !writeEnableLatch)
    else $error("latch still set as busy rose");
  a_busy_after_frame: assert property ($rose(busy) |-> chipSelN)
    else $error("busy rose inside a frame");
  a_latch_idle_only: assert property ($rose(writeEnableLatch) |-> !busy)
    else $error("latch set while busy");
  a_latch_after_frame: assert property ($rose(writeEnableLatch) |-> chipSelN)
    else $error("latch set inside a frame");
  a_suspend_after_frame: assert property ($rose(suspendFlag) |-> chipSelN)
    else $error("suspend flag set inside a frame");
  a_busy_ends_resumed: assert property ($fell(busy) |-> !suspendFlag)
    else $error("busy ended while suspended");
  a_quad_no_pins: assert property (quadEnable && $past(quadEnable) |->
    !holdActive && !pinResetActive)
    else $error("pin function active with quad on");
  a_pin_fn_excl: assert property (!(holdActive && pinResetActive))
    else $error("hold and reset both active");
  a_prot_after_frame: assert property ($changed(blockProtect) |-> chipSelN)
    else $error("protect field changed inside a frame");
  a_drive_in_frame: assert property ($rose(serialOutEn) |-> !chipSelN)
    else $error("read data driven outside a frame");
endmodule

bind fsp_status_protect fsp_status_protect_properties chk (
  .mclk(mclk),
  .arst_n(arst_n),
  .chipSelN(chipSelN),
  .serialOutEn(serialOutEn),
  .blockProtect(blockProtect),
  .busy(busy),
  .writeEnableLatch(writeEnableLatch),
  .suspendFlag(suspendFlag),
  .quadEnable(quadEnable),
  .holdActive(holdActive),
  .pinResetActive(pinResetActive)
);

// file: sim/fsp_testbench.sv
// Self-checking bench: status bits read back over the serial link.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic factoryRst_n = 1'b0;
  logic writeProtectN = 1'b1;
  logic holdResetN = 1'b1;
  wire chipSelN, sclk, serialIn, serialOut, serialOutEn;
  wire [2:0] blockProtect, securityLock;
  wire topBottomSelect, granularitySelect, complementProtect;
  wire busy, writeEnableLatch, suspendFlag, quadEnable, holdActive, pinResetActive;
  int bad_count = 0;
  int num_checks = 0;
  logic [7:0] rx;

  always #50 mclk = ~mclk;

  fsp_host_model host (.mclk(mclk), .chipSelN(chipSelN), .sclk(sclk),
    .serialIn(serialIn), .serialOut(serialOut));

  // Short busy counts keep the run brief; program stays long enough to poll
  fsp_status_protect #(.WRSR_CYCLES(100), .PROG_CYCLES(400), .SE_CYCLES(400),
    .BE_CYCLES(50), .CE_CYCLES(50)) DUT (.mclk(mclk), .arst_n(arst_n),
    .factoryRst_n(factoryRst_n), .chipSelN(chipSelN), .sclk(sclk),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .writeProtectN(writeProtectN), .holdResetN(holdResetN),
    .blockProtect(blockProtect), .topBottomSelect(topBottomSelect),
    .granularitySelect(granularitySelect), .complementProtect(complementProtect),
    .securityLock(securityLock), .busy(busy), .writeEnableLatch(writeEnableLatch),
    .suspendFlag(suspendFlag), .quadEnable(quadEnable), .holdActive(holdActive),
    .pinResetActive(pinResetActive));

  // --------------------
  // Shared tasks
  // --------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic snd(input logic [31:0] tx, input int nb);
    host.xfer(tx, nb, rx);
  endtask

  task automatic wr(input logic [31:0] tx, input int nb);
    snd(32'h06000000, 1);
    snd(tx, nb);
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    host.xfer({op, 24'h000000}, 2, rx);
    chk(rx, exp);
  endtask

  task automatic idle();
    int n = 0;
    while (busy !== 1'b0) begin
      @(posedge mclk);
      #5;
      n++;
      if (n > 600) begin
        bad_count++;
        $display("FAIL %0t busy never cleared", $time);
        test_done();
      end
    end
  endtask

  task automatic pwr();
    arst_n = 1'b0;
    repeat (20) @(posedge mclk);
    #5 arst_n = 1'b1;
    repeat (15) @(posedge mclk);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_wel();
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h00);
    snd(32'h06000000, 1);
    rd(8'h05, 8'h02);
    snd(32'h04000000, 1);
    rd(8'h05, 8'h00);
  endtask

  task automatic t_nv();
    // Write-protect low has no say in mode 00; data bits 1:0 set on purpose
    writeProtectN = 1'b0;
    wr(32'h017F4000, 3);
    chk({6'h00, busy, writeEnableLatch}, 8'h02);
    idle();
    rd(8'h05, 8'h7C);
    rd(8'h35, 8'h40);
    chk({3'h0, granularitySelect, topBottomSelect, blockProtect}, 8'h1F);
    chk({7'h00, complementProtect}, 8'h01);
    writeProtectN = 1'b1;
  endtask

  task automatic t_ops();
    logic [7:0] ops [6] = '{8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    for (int i = 0; i < 6; i++) begin
      wr({ops[i], 24'h000000}, i < 4 ? 4 : 1);
      chk({6'h00, busy, writeEnableLatch}, 8'h02);
      if (i == 0) begin
        snd(32'h06000000, 1);
        rd(8'h05, 8'h7D);
        snd(32'h75000000, 1);
        rd(8'h35, 8'hC0);
        snd(32'h7A000000, 1);
        chk({7'h00, suspendFlag}, 8'h00);
      end
      idle();
    end
  endtask

  task automatic t_vol();
    snd(32'h50000000, 1);
    snd(32'h01003800, 3);
    chk({7'h00, busy}, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h00);
    pwr();
    rd(8'h05, 8'h7C);
    wr(32'h31480000, 2);
    idle();
    wr(32'h31400000, 2);
    idle();
    rd(8'h35, 8'h48);
    chk({5'h00, securityLock}, 8'h01);
  endtask

  task automatic t_pins();
    wr(32'h11800000, 2);
    idle();
    holdResetN = 1'b0;
    repeat (6) @(posedge mclk);
    chk({7'h00, pinResetActive}, 8'h01);
    #5 holdResetN = 1'b1;
    // Pins stay driven by the bench before quad is turned on
    wr(32'h314A0000, 2);
    idle();
    chk({7'h00, quadEnable}, 8'h01);
    holdResetN = 1'b0;
    repeat (6) @(posedge mclk);
    chk({6'h00, holdActive, pinResetActive}, 8'h00);
    #5 holdResetN = 1'b1;
    wr(32'h31480000, 2);
    idle();
    wr(32'h11000000, 2);
    idle();
  endtask

  task automatic t_prot();
    wr(32'h01FC4800, 3);
    idle();
    rd(8'h05, 8'hFC);
    writeProtectN = 1'b0;
    wr(32'h017C4800, 3);
    chk({7'h00, busy}, 8'h00);
    rd(8'h05, 8'hFC);
    writeProtectN = 1'b1;
    wr(32'h017C4900, 3);
    idle();
    wr(32'h01004800, 3);
    rd(8'h05, 8'h7C);
    pwr();
    rd(8'h35, 8'h48);
    // Lock-down again, then leave it by software reset
    wr(32'h017C4900, 3);
    idle();
    snd(32'h66000000, 1);
    snd(32'h99000000, 1);
    rd(8'h35, 8'h48);
    wr(32'h01FC4900, 3);
    idle();
    pwr();
    wr(32'h01004800, 3);
    rd(8'h05, 8'hFC);
    rd(8'h35, 8'h49);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    #5 factoryRst_n = 1'b1;
    pwr();
    t_wel();
    t_nv();
    t_ops();
    t_vol();
    t_pins();
    t_prot();
    test_done();
  end
endmodule
